// ===== core/texel_decode_defs.svh
// Constants for the texture texel format decoder.
`ifndef TEXEL_DECODE_DEFS_SVH
`define TEXEL_DECODE_DEFS_SVH
`define PARAM_TYPE_TEXTURE 8'h02
`define SUBTYPE_GROUP_TEXTURE 4'h0
`define SUBTYPE_GROUP_STAGE 4'h2
`define SUBADDR_DECODE_CTRL 8'h30
`define SUBADDR_FLAG_ONE 8'h50
`define SUBADDR_FLAG_TWO 8'h51
`define SUBADDR_LAST 8'h51
`define CTRL_WIDTH 24
`define FLAG_WIDTH 16
`define FMT_HI 23
`define FMT_LO 19
`define SUBF_HI 18
`define SUBF_LO 16
`define WIDEN_ZERO_BIT 15
`define ORDER_INVERSE_BIT 14
`define ZMAP_HI 13
`define ZMAP_LO 11
`define DEGAMMA_BIT 8
`define CONV_HI 1
`define CONV_LO 0
`define FMT_YUV 5'h06
`define FMT_ABGR16 5'h15
`define FMT_RGBA32 5'h1B
`define FMT_BGRA32 5'h1D
`define FMT_FLOAT 5'h1E
`define FMT_DEPTH 5'h1F
`define SUBF_8880 3'h0
`define SUBF_8888 3'h1
`define SUBF_1010102 3'h2
`define SUBF_555 3'h0
`define SUBF_565 3'h1
`define SUBF_1555 3'h2
`define SUBF_4444 3'h3
`define SUBF_565_READ555 3'h5
`define SUBF_R16F 3'h0
`define SUBF_G16R16F 3'h4
`define SUBF_R32F 3'h5
`define SUBF_Z16 3'h0
`define SUBF_Z16F 3'h1
`define SUBF_Z32 3'h4
`define SUBF_Z32F 3'h5
`define SUBF_Z24S8 3'h6
`define ZMAP_GREEN 3'h0
`define ZMAP_LUMINANCE 3'h2
`define ZMAP_INTENSITY 3'h4
`define ZMAP_ALPHA 3'h6
`define CONV_PASS 2'h0
`define CONV_SDTV 2'h1
`define CONV_HDTV 2'h2
`define FIX_ONE 24'hFFFFFF
`define FLT_ONE 24'h3F0000
`define HALF_REBIAS 7'h30
`define SGL_REBIAS 8'h40
`define SGL_EXP_MIN 8'h41
`define SGL_EXP_MAX 8'hBE
`define Y_OFFSET 16
`define C_OFFSET 128
`define COEF_FRAC 10
`define COEF_ROUND 512
`define SD_Y 1192
`define SD_Y_BLUE 1193
`define SD_RV 1634
`define SD_GU 401
`define SD_GV 832
`define SD_BU 2066
`define HD_RU 0
`define HD_RV 1836
`define HD_GU 218
`define HD_GV 546
`define HD_BU 2264
`define HD_BV 0
`define MAX8 255
`define MAX10 1023
`endif

// ===== core/texel_decode_pkg.sv
// Types shared by the texture texel format decoder.
package texel_decode_pkg;
  typedef struct packed {
    logic valid;
    logic [7:0] parameter_type_code;
    logic [7:0] parameter_subtype_code;
    logic [31:0] word;
  } param_word_s;
  typedef struct packed {
    logic valid;
    logic [3:0] slot;
    logic [31:0] data;
    logic [1:0] index_bits;
    logic [2:0] index_pos;
  } texel_in_s;
  typedef struct packed {
    logic ten_bit;
    logic signed [15:0] a, b1, b2, b3, c1, c2, c3, d;
  } yuv_coef_s;
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } gamma_wr_s;
  typedef struct packed {
    logic valid;
    logic is_float;
    logic [23:0] r, g, b, a;
    logic [7:0] stencil;
    logic [3:0] index;
    logic [15:0] flag_one, flag_two;
  } texel_out_s;
endpackage : texel_decode_pkg

// ===== core/channel_widen.sv
// Widens a narrow colour channel to 24 bits by replication or zero fill.
`timescale 1ns/1ps
`default_nettype none
module channel_widen (
  input wire logic [9:0] i_val,
  input wire logic [3:0] i_bits,
  input wire logic i_zero_fill,
  output logic [23:0] o_val
);
  always_comb begin
    int w;
    int k;
    w = int'(i_bits);
    k = 0;
    o_val = '0;
    for (int i = 0; i < 24; i++) begin
      if (w > 0 && !(i_zero_fill && i >= w)) begin
        k = w - 1 - (i % w);
        o_val[23 - i] = i_val[k];
      end
    end
  end
endmodule : channel_widen
`default_nettype wire

// ===== core/yuv_convert.sv
// Converts video YUV samples to RGB with fixed or programmable weights.
`timescale 1ns/1ps
`default_nettype none
`include "texel_decode_defs.svh"
module yuv_convert (
  input wire logic [9:0] i_y,
  input wire logic [9:0] i_u,
  input wire logic [9:0] i_v,
  input wire logic [1:0] i_mode,
  input wire texel_decode_pkg::yuv_coef_s i_coef,
  output logic [9:0] o_r,
  output logic [9:0] o_g,
  output logic [9:0] o_b
);
  import texel_decode_pkg::*;

  function automatic logic [9:0] finish(input int s, input logic ten);
    int t;
    int lim;
    lim = ten ? `MAX10 : `MAX8;
    t = ten ? s + (s >>> 10) : s + (s >>> 8);
    t = (t + `COEF_ROUND) >>> `COEF_FRAC;
    if (t < 0) t = 0;
    if (t > lim) t = lim;
    return 10'(t);
  endfunction : finish

  always_comb begin
    int y;
    int u;
    int v;
    int sh;
    y = int'(i_y);
    u = int'(i_u);
    v = int'(i_v);
    sh = i_coef.ten_bit ? 2 : 0;
    o_r = '0;
    o_g = '0;
    o_b = '0;
    case (i_mode)
      `CONV_SDTV, `CONV_HDTV: begin
        y = y - (`Y_OFFSET << sh);
        u = u - (`C_OFFSET << sh);
        v = v - (`C_OFFSET << sh);
        if (i_mode == `CONV_SDTV) begin
          o_r = finish(y * `SD_Y + v * `SD_RV, i_coef.ten_bit);
          o_g = finish(y * `SD_Y - u * `SD_GU - v * `SD_GV, i_coef.ten_bit);
          o_b = finish(y * `SD_Y_BLUE + u * `SD_BU, i_coef.ten_bit);
        end else begin
          o_r = finish(y * `SD_Y - u * `HD_RU + v * `HD_RV, i_coef.ten_bit);
          o_g = finish(y * `SD_Y - u * `HD_GU - v * `HD_GV, i_coef.ten_bit);
          o_b = finish(y * `SD_Y_BLUE + u * `HD_BU - v * `HD_BV,
                       i_coef.ten_bit);
        end
      end
      `CONV_PASS: begin
        o_r = i_u;
        o_g = i_y;
        o_b = i_v;
      end
      default: begin
        o_r = finish(y * int'(i_coef.a) + u * int'(i_coef.b1)
                     + v * int'(i_coef.c1) + int'(i_coef.d), i_coef.ten_bit);
        o_g = finish(y * int'(i_coef.a) + u * int'(i_coef.b2)
                     + v * int'(i_coef.c2) + int'(i_coef.d), i_coef.ten_bit);
        o_b = finish(y * int'(i_coef.a) + u * int'(i_coef.b3)
                     + v * int'(i_coef.c3) + int'(i_coef.d), i_coef.ten_bit);
      end
    endcase
  end
endmodule : yuv_convert
`default_nettype wire

// ===== core/texel_format_decoder.sv
// Texture texel format decoder with per-slot parameter registers.
`timescale 1ns/1ps
`default_nettype none
`include "texel_decode_defs.svh"
module texel_format_decoder (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire texel_decode_pkg::param_word_s i_param,
  input wire texel_decode_pkg::gamma_wr_s i_gamma_wr,
  input wire texel_decode_pkg::yuv_coef_s i_yuv_coef,
  input wire texel_decode_pkg::texel_in_s i_texel,
  output texel_decode_pkg::texel_out_s o_texel
);
  import texel_decode_pkg::*;
  typedef struct packed {
    texel_out_s out;
  } state_s;
  logic [1:0] rst_sync_q;
  logic rstn;
  state_s st_q;
  state_s st_d;
  logic [`CTRL_WIDTH-1:0] ctrl_q [16];
  logic [`FLAG_WIDTH-1:0] flag_one_q [16];
  logic [`FLAG_WIDTH-1:0] flag_two_q [16];
  logic [7:0] gamma_q [256];
  logic [7:0] sub_addr;
  logic [3:0] sub_group;
  logic [3:0] sub_slot;
  logic is_tex_param;
  logic wr_ctrl;
  logic wr_flag_one;
  logic wr_flag_two;
  logic [`CTRL_WIDTH-1:0] cur_ctrl;
  logic [4:0] fmt;
  logic [2:0] subf;
  logic [1:0] conv;
  logic zero_fill;
  logic [9:0] raw_v [4];
  logic [3:0] raw_w [4];
  logic [23:0] wide [4];
  logic [9:0] yuv_r;
  logic [9:0] yuv_g;
  logic [9:0] yuv_b;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rstn = rst_sync_q[1];
  // Parameter word decode: type, subtype group and sub-address.
  assign sub_addr = i_param.word[31:24];
  assign sub_group = i_param.parameter_subtype_code[7:4];
  assign sub_slot = i_param.parameter_subtype_code[3:0];
  assign is_tex_param = i_param.valid
                        && i_param.parameter_type_code == `PARAM_TYPE_TEXTURE;
  assign wr_ctrl = is_tex_param && sub_group == `SUBTYPE_GROUP_TEXTURE
                   && sub_addr == `SUBADDR_DECODE_CTRL;
  assign wr_flag_one = is_tex_param
                       && sub_group == `SUBTYPE_GROUP_STAGE
                       && sub_addr == `SUBADDR_FLAG_ONE;
  assign wr_flag_two = is_tex_param && sub_group == `SUBTYPE_GROUP_STAGE
                       && sub_addr == `SUBADDR_FLAG_TWO;

  // Only exact matches store; any other address touches nothing.
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 16; i++) begin
        ctrl_q[i] <= '0;
        flag_one_q[i] <= '0;
        flag_two_q[i] <= '0;
      end
    end else begin
      if (wr_ctrl) begin
        ctrl_q[sub_slot] <= i_param.word[23:0];
      end
      if (wr_flag_one) begin
        flag_one_q[sub_slot] <= i_param.word[15:0];
      end
      if (wr_flag_two) begin
        flag_two_q[sub_slot] <= i_param.word[15:0];
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_gamma_wr.en) begin
      gamma_q[i_gamma_wr.addr] <= i_gamma_wr.data;
    end
  end
  assign cur_ctrl = ctrl_q[i_texel.slot];
  assign fmt = cur_ctrl[`FMT_HI:`FMT_LO];
  assign subf = cur_ctrl[`SUBF_HI:`SUBF_LO];
  assign conv = cur_ctrl[`CONV_HI:`CONV_LO];
  assign zero_fill = cur_ctrl[`WIDEN_ZERO_BIT]
                     || (fmt == `FMT_YUV && conv == `CONV_PASS);
  yuv_convert u_yuv (
    .i_y(i_texel.data[29:20]),
    .i_u(i_texel.data[19:10]),
    .i_v(i_texel.data[9:0]),
    .i_mode(conv),
    .i_coef(i_yuv_coef),
    .o_r(yuv_r),
    .o_g(yuv_g),
    .o_b(yuv_b)
  );
  // Channel order is red, green, blue, alpha; alpha never zero fills.
  for (genvar c = 0; c < 4; c++) begin : g_widen
    channel_widen u_widen (
      .i_val(raw_v[c]),
      .i_bits(raw_w[c]),
      .i_zero_fill(c == 3 ? 1'b0 : zero_fill),
      .o_val(wide[c])
    );
  end
  function automatic logic [23:0] half_to_wide(input logic [15:0] h);
    logic [6:0] e;
    e = (h[14:10] == 5'h00) ? 7'h00 : {2'h0, h[14:10]} + `HALF_REBIAS;
    return {h[15], e, h[9:0], 6'h00};
  endfunction : half_to_wide
  function automatic logic [23:0] single_to_wide(input logic [31:0] f);
    logic [7:0] e;
    e = f[30:23];
    if (e < `SGL_EXP_MIN) return 24'h000000;
    if (e > `SGL_EXP_MAX) return {f[31], 7'h7F, 16'hFFFF};
    return {f[31], 7'(e - `SGL_REBIAS), f[22:7]};
  endfunction : single_to_wide
  // Raw channel extraction per format and subformat.
  always_comb begin
    logic [31:0] d;
    d = i_texel.data;
    for (int c = 0; c < 4; c++) begin
      raw_v[c] = '0;
      raw_w[c] = 4'h8;
    end
    raw_v[3] = 10'h3FF;
    raw_w[3] = 4'h1;
    case (fmt)
      `FMT_ABGR16: begin
        raw_v[2] = {5'h00, d[15:11]};
        raw_v[1] = {5'h00, d[10:6]};
        raw_v[0] = {5'h00, d[5:1]};
        raw_w[0] = 4'h5;
        raw_w[1] = 4'h5;
        raw_w[2] = 4'h5;
        case (subf)
          `SUBF_565: begin
            raw_v[1] = {4'h0, d[10:5]};
            raw_w[1] = 4'h6;
            raw_v[0] = {5'h00, d[4:0]};
          end
          `SUBF_1555: begin
            raw_v[3] = {9'h000, d[0]};
          end
          `SUBF_4444: begin
            raw_v[2] = {6'h00, d[15:12]};
            raw_v[1] = {6'h00, d[11:8]};
            raw_v[0] = {6'h00, d[7:4]};
            raw_v[3] = {6'h00, d[3:0]};
            for (int c = 0; c < 4; c++) raw_w[c] = 4'h4;
          end
          `SUBF_565_READ555: begin
            raw_v[0] = {5'h00, d[4:0]};
          end
          default: begin
          end
        endcase
      end
      `FMT_RGBA32, `FMT_BGRA32: begin
        raw_v[0] = {2'h0, d[31:24]};
        raw_v[1] = {2'h0, d[23:16]};
        raw_v[2] = {2'h0, d[15:8]};
        if (subf == `SUBF_8888) begin
          raw_v[3] = {2'h0, d[7:0]};
          raw_w[3] = 4'h8;
        end else if (subf == `SUBF_1010102) begin
          raw_v[0] = d[31:22];
          raw_v[1] = d[21:12];
          raw_v[2] = d[11:2];
          raw_v[3] = {8'h00, d[1:0]};
          raw_w[3] = 4'h2;
          for (int c = 0; c < 3; c++) raw_w[c] = 4'hA;
        end
        if (fmt == `FMT_BGRA32) begin
          raw_v[0] = raw_v[2];
          raw_v[2] = (subf == `SUBF_1010102) ? d[31:22] : {2'h0, d[31:24]};
        end
      end
      `FMT_YUV: begin
        raw_v[0] = yuv_r;
        raw_v[1] = yuv_g;
        raw_v[2] = yuv_b;
        for (int c = 0; c < 3; c++) begin
          raw_w[c] = i_yuv_coef.ten_bit ? 4'hA : 4'h8;
        end
      end
      default: begin
      end
    endcase
  end
  // Final assembly: float and depth paths, degamma, index pick.
  always_comb begin
    logic [31:0] d;
    logic [23:0] z;
    logic [23:0] one;
    logic [3:0] bits;
    logic [3:0] shift;
    logic [7:0] picked;
    d = i_texel.data;
    z = '0;
    one = '0;
    shift = '0;
    picked = '0;
    bits = 4'h1 << i_texel.index_bits;
    st_d = st_q;
    st_d.out.valid = i_texel.valid;
    st_d.out.is_float = 1'b0;
    st_d.out.stencil = '0;
    st_d.out.r = wide[0];
    st_d.out.g = wide[1];
    st_d.out.b = wide[2];
    st_d.out.a = wide[3];
    st_d.out.flag_one = flag_one_q[i_texel.slot];
    st_d.out.flag_two = flag_two_q[i_texel.slot];
    if (cur_ctrl[`DEGAMMA_BIT]) begin
      st_d.out.r = {3{gamma_q[wide[0][23:16]]}};
      st_d.out.g = {3{gamma_q[wide[1][23:16]]}};
      st_d.out.b = {3{gamma_q[wide[2][23:16]]}};
    end
    if (fmt == `FMT_FLOAT) begin
      st_d.out.is_float = 1'b1;
      st_d.out.r = half_to_wide(d[15:0]);
      st_d.out.g = `FLT_ONE;
      st_d.out.b = `FLT_ONE;
      st_d.out.a = `FLT_ONE;
      if (subf == `SUBF_G16R16F) begin
        st_d.out.g = half_to_wide(d[31:16]);
      end else if (subf == `SUBF_R32F) begin
        st_d.out.r = single_to_wide(d);
      end
    end
    if (fmt == `FMT_DEPTH) begin
      case (subf)
        `SUBF_Z16: z = {d[15:0], d[15:8]};
        `SUBF_Z16F: z = half_to_wide(d[15:0]);
        `SUBF_Z32: z = d[31:8];
        `SUBF_Z32F: z = single_to_wide(d);
        `SUBF_Z24S8: begin
          z = d[31:8];
          st_d.out.stencil = d[7:0];
        end
        default: z = '0;
      endcase
      st_d.out.is_float = (subf == `SUBF_Z16F || subf == `SUBF_Z32F);
      one = st_d.out.is_float ? `FLT_ONE : `FIX_ONE;
      st_d.out.r = '0;
      st_d.out.g = z;
      st_d.out.b = '0;
      st_d.out.a = one;
      case (cur_ctrl[`ZMAP_HI:`ZMAP_LO])
        `ZMAP_LUMINANCE: begin
          st_d.out.r = z;
          st_d.out.b = z;
        end
        `ZMAP_INTENSITY: begin
          st_d.out.r = z;
          st_d.out.b = z;
          st_d.out.a = z;
        end
        `ZMAP_ALPHA: begin
          st_d.out.g = '0;
          st_d.out.a = z;
        end
        default: begin
        end
      endcase
    end
    if (cur_ctrl[`ORDER_INVERSE_BIT]) begin
      shift = 4'h8 - 4'({1'b0, i_texel.index_pos} + 4'h1) * bits;
    end else begin
      shift = 4'({1'b0, i_texel.index_pos} * bits);
    end
    picked = d[7:0] >> shift;
    st_d.out.index = picked[3:0] & 4'(~(4'hF << bits));
  end
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign o_texel = st_q.out;
  sequence s_tex(logic [4:0] f, logic [2:0] s);
    i_texel.valid && fmt == f && subf == s;
  endsequence
  sequence s_fix_plain;
    !cur_ctrl[`DEGAMMA_BIT];
  endsequence
  chk_ctrl_store: assert property (@(posedge i_clk) disable iff (!rstn)
    wr_ctrl |=> ctrl_q[$past(sub_slot)] == $past(i_param.word[23:0]))
    else $error("decode control word not stored");
  chk_flag_store: assert property (@(posedge i_clk) disable iff (!rstn)
    wr_flag_two |=> flag_two_q[$past(sub_slot)] == $past(i_param.word[15:0]))
    else $error("second flag number not stored");
  chk_reserved_quiet: assert property (
    @(posedge i_clk) disable iff (!rstn)
    (is_tex_param && sub_addr > `SUBADDR_LAST && !i_texel.valid)
    |=> $stable(ctrl_q[0]) && $stable(flag_one_q[0]))
    else $error("reserved sub-address changed state");
  chk_alpha_one: assert property (@(posedge i_clk) disable iff (!rstn)
    s_tex(`FMT_RGBA32, `SUBF_8880) |=> o_texel.valid && o_texel.a == `FIX_ONE)
    else $error("missing alpha not forced to one");
  chk_read_555: assert property (@(posedge i_clk) disable iff (!rstn)
    s_tex(`FMT_ABGR16, `SUBF_565_READ555) ##0 s_fix_plain
    |=> o_texel.g[23:19] == $past(i_texel.data[10:6]))
    else $error("green not read from bits 10 to 6");
  chk_zero_fill: assert property (@(posedge i_clk) disable iff (!rstn)
    s_tex(`FMT_RGBA32, `SUBF_8888) ##0 s_fix_plain
    ##0 cur_ctrl[`WIDEN_ZERO_BIT]
    |=> o_texel.r[15:0] == 16'h0000 && o_texel.a[15:8] == o_texel.a[23:16])
    else $error("zero fill or alpha replication wrong");
  chk_depth_alpha: assert property (
    @(posedge i_clk) disable iff (!rstn)
    (i_texel.valid && fmt == `FMT_DEPTH
     && cur_ctrl[`ZMAP_HI:`ZMAP_LO] == `ZMAP_ALPHA)
    |=> o_texel.r == 24'h000000 && o_texel.g == 24'h000000)
    else $error("alpha depth mode leaked into colour");
  chk_float_one: assert property (@(posedge i_clk) disable iff (!rstn)
    s_tex(`FMT_FLOAT, `SUBF_R16F)
    |=> o_texel.is_float && o_texel.b == `FLT_ONE && o_texel.a == `FLT_ONE)
    else $error("float red format channels not one");
  chk_stencil: assert property (@(posedge i_clk) disable iff (!rstn)
    s_tex(`FMT_DEPTH, `SUBF_Z24S8)
    |=> o_texel.stencil == $past(i_texel.data[7:0]))
    else $error("stencil not taken from low byte");
  chk_order_inv: assert property (@(posedge i_clk) disable iff (!rstn)
    (i_texel.valid && cur_ctrl[`ORDER_INVERSE_BIT]
     && i_texel.index_bits == 2'h2 && i_texel.index_pos == 3'h0)
    |=> o_texel.index == $past(i_texel.data[7:4]))
    else $error("inverse order picked wrong nibble");
endmodule : texel_format_decoder
`default_nettype wire

// ===== bench/param_writer.sv
// Command stream parser model that writes texture parameter words.
`timescale 1ns/1ps
`default_nettype none
module param_writer (
  input wire logic i_clk,
  output texel_decode_pkg::param_word_s o_param
);
  import texel_decode_pkg::*;
  initial o_param = '0;
  // One word per call; released fields show inverted junk.
  task automatic put(input logic [7:0] ty, input logic [7:0] st,
                     input logic [31:0] w);
    @(negedge i_clk);
    o_param <= '{1'b1, ty, st, w};
    @(negedge i_clk);
    o_param <= '{1'b0, ~ty, ~st, ~w};
  endtask : put
endmodule : param_writer
`default_nettype wire

// ===== bench/texture_texel_format_decoder_bench.sv
// Self-checking bench for the texture texel format decoder.
`timescale 1ns/1ps
`default_nettype none
module texture_texel_format_decoder_bench;
  import texel_decode_pkg::*;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  param_word_s prm;
  gamma_wr_s gw = '0;
  yuv_coef_s coef = '0;
  texel_in_s tin = '0;
  texel_out_s tout;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  always #10 i_clk = ~i_clk;
  param_writer pw (.i_clk(i_clk), .o_param(prm));
  texel_format_decoder uut (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_param(prm), .i_gamma_wr(gw), .i_yuv_coef(coef), .i_texel(tin),
    .o_texel(tout));
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_fail++;
      end_sim;
    end
  end
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  function automatic logic [23:0] wid(input logic [9:0] v, input int n,
                                      input logic z);
    logic [23:0] r;
    for (int i = 0; i < 24; i++) begin
      r[23-i] = (z && i >= n) ? 1'b0 : v[n-1-(i%n)];
    end
    return r;
  endfunction : wid
  // Control payload; m holds bits 15:8 of the word.
  function automatic logic [23:0] cw(input logic [4:0] f,
    input logic [2:0] sf, input logic [7:0] m, input logic [1:0] cv);
    return {f, sf, m, 6'h00, cv};
  endfunction : cw
  task automatic run(input logic [3:0] sl, input logic [23:0] c,
    input logic [31:0] d, input logic [1:0] ib = 2'h0,
    input logic [2:0] ip = 3'h0);
    pw.put(8'h02, {4'h0, sl}, {8'h30, c});
    @(negedge i_clk);
    tin <= '{1'b1, sl, d, ib, ip};
    @(negedge i_clk);
    tin.valid <= 1'b0;
    chk({23'h0, tout.valid}, 24'h1);
  endtask : run
  task automatic px(input logic [23:0] r, input logic [23:0] g,
                    input logic [23:0] b, input logic [23:0] a);
    chk(tout.r, r);
    chk(tout.g, g);
    chk(tout.b, b);
    chk(tout.a, a);
  endtask : px
  task automatic t_flags;
    pw.put(8'h02, 8'h25, 32'h505A1234);
    pw.put(8'h02, 8'h25, 32'h515AABCD);
    pw.put(8'h02, 8'h05, 32'h50009999);
    pw.put(8'h03, 8'h25, 32'h50007777);
    pw.put(8'h02, 8'h25, 32'h2F004444);
    pw.put(8'h02, 8'h00, 32'h60AAAAAA);
    run(4'h5, cw(5'h1B, 3'h1, 8'h00, 2'h0), 32'h0);
    chk({8'h0, tout.flag_one}, 24'h1234);
    chk({8'h0, tout.flag_two}, 24'hABCD);
    run(4'h6, cw(5'h1B, 3'h1, 8'h00, 2'h0), 32'h0);
    chk({8'h0, tout.flag_one}, 24'h0);
  endtask : t_flags
  task automatic t_rgba;
    run(4'h1, cw(5'h1B, 3'h0, 8'h00, 2'h0), 32'h12345678);
    px(24'h121212, 24'h343434, 24'h565656, 24'hFFFFFF);
    run(4'h1, cw(5'h1B, 3'h1, 8'h00, 2'h0), 32'h12345678);
    px(24'h121212, 24'h343434, 24'h565656, 24'h787878);
    run(4'h1, cw(5'h1B, 3'h1, 8'h80, 2'h0), 32'h12345678);
    px(24'h120000, 24'h340000, 24'h560000, 24'h787878);
    run(4'h1, cw(5'h1B, 3'h2, 8'h00, 2'h0), 32'h12345678);
    px(wid(10'h048, 10, 0), wid(10'h345, 10, 0), wid(10'h19E, 10, 0),
       24'h0);
    run(4'h2, cw(5'h1D, 3'h0, 8'h00, 2'h0), 32'h12345678);
    px(24'h565656, 24'h343434, 24'h121212, 24'hFFFFFF);
    run(4'h2, cw(5'h1D, 3'h1, 8'h00, 2'h0), 32'h12345678);
    chk(tout.a, 24'h787878);
    run(4'h2, cw(5'h1D, 3'h2, 8'h00, 2'h0), 32'h12345678);
    px(wid(10'h19E, 10, 0), wid(10'h345, 10, 0), wid(10'h048, 10, 0),
       24'h0);
  endtask : t_rgba
  task automatic t_bgr16;
    run(4'h3, cw(5'h15, 3'h0, 8'h00, 2'h0), 32'hA5C3);
    px(wid(1, 5, 0), wid(10'h17, 5, 0), wid(10'h14, 5, 0),
       24'hFFFFFF);
    run(4'h3, cw(5'h15, 3'h1, 8'h00, 2'h0), 32'hA5C3);
    px(wid(3, 5, 0), wid(10'h2E, 6, 0), wid(10'h14, 5, 0),
       24'hFFFFFF);
    run(4'h3, cw(5'h15, 3'h2, 8'h80, 2'h0), 32'hA5C2);
    px(wid(1, 5, 1), wid(10'h17, 5, 1), wid(10'h14, 5, 1), 24'h0);
    run(4'h3, cw(5'h15, 3'h3, 8'h80, 2'h0), 32'hA5C3);
    px(wid(10'hC, 4, 1), wid(5, 4, 1), wid(10'hA, 4, 1),
       wid(3, 4, 0));
    run(4'h3, cw(5'h15, 3'h5, 8'h00, 2'h0), 32'hA5C3);
    px(wid(3, 5, 0), wid(10'h17, 5, 0), wid(10'h14, 5, 0),
       24'hFFFFFF);
  endtask : t_bgr16
  task automatic t_float;
    run(4'h4, cw(5'h1E, 3'h0, 8'h00, 2'h0), 32'h7777C000);
    px(24'hC00000, 24'h3F0000, 24'h3F0000, 24'h3F0000);
    chk({23'h0, tout.is_float}, 24'h1);
    run(4'h4, cw(5'h1E, 3'h4, 8'h00, 2'h0), 32'h3C00C000);
    px(24'hC00000, 24'h3F0000, 24'h3F0000, 24'h3F0000);
    run(4'h4, cw(5'h1E, 3'h5, 8'h00, 2'h0), 32'h40000000);
    chk(tout.r, 24'h400000);
    run(4'h4, cw(5'h1E, 3'h5, 8'h00, 2'h0), 32'h7F000000);
    chk(tout.r, 24'h7FFFFF);
  endtask : t_float
  task automatic t_depth;
    run(4'h7, cw(5'h1F, 3'h0, 8'h00, 2'h0), 32'h0000ABCD);
    px(24'h0, 24'hABCDAB, 24'h0, 24'hFFFFFF);
    run(4'h7, cw(5'h1F, 3'h4, 8'h10, 2'h0), 32'hABCDEF5A);
    px(24'hABCDEF, 24'hABCDEF, 24'hABCDEF, 24'hFFFFFF);
    run(4'h7, cw(5'h1F, 3'h6, 8'h20, 2'h0), 32'hABCDEF5A);
    px(24'hABCDEF, 24'hABCDEF, 24'hABCDEF, 24'hABCDEF);
    chk({16'h0, tout.stencil}, 24'h5A);
    run(4'h7, cw(5'h1F, 3'h6, 8'h30, 2'h0), 32'hABCDEF5A);
    px(24'h0, 24'h0, 24'h0, 24'hABCDEF);
  endtask : t_depth
  task automatic t_index;
    run(4'h8, cw(5'h1B, 3'h1, 8'h00, 2'h0), 32'h1E, 2'h2, 3'h0);
    chk({20'h0, tout.index}, 24'hE);
    run(4'h8, cw(5'h1B, 3'h1, 8'h40, 2'h0), 32'h1E, 2'h2, 3'h0);
    chk({20'h0, tout.index}, 24'h1);
    run(4'h8, cw(5'h1B, 3'h1, 8'h00, 2'h0), 32'h1E, 2'h0, 3'h1);
    chk({20'h0, tout.index}, 24'h1);
    run(4'h8, cw(5'h1B, 3'h1, 8'h40, 2'h0), 32'h1E, 2'h0, 3'h1);
    chk({20'h0, tout.index}, 24'h0);
  endtask : t_index
  task automatic t_yuv;
    run(4'h9, cw(5'h06, 3'h0, 8'h00, 2'h0), {2'h0, 10'h80, 10'h40, 10'hC0});
    px(24'h400000, 24'h800000, 24'hC00000, 24'hFFFFFF);
    for (int m = 1; m < 3; m++) begin
      run(4'h9, cw(5'h06, 3'h0, 8'h00, m[1:0]),
          {2'h0, 10'hEB, 10'h80, 10'h80});
      px(24'hFFFFFF, 24'hFFFFFF, 24'hFFFFFF, 24'hFFFFFF);
      run(4'h9, cw(5'h06, 3'h0, 8'h00, m[1:0]),
          {2'h0, 10'h10, 10'h80, 10'h80});
      px(24'h0, 24'h0, 24'h0, 24'hFFFFFF);
    end
    coef <= '{ten_bit: 1'b0, a: 16'sh0400, b1: 16'sh0400,
              default: 16'sh0000};
    run(4'h9, cw(5'h06, 3'h0, 8'h00, 2'h3), {2'h0, 10'h40, 10'h20, 10'h10});
    px(24'h606060, 24'h404040, 24'h404040, 24'hFFFFFF);
  endtask : t_yuv
  task automatic t_gamma;
    for (int i = 0; i < 3; i++) begin
      @(negedge i_clk);
      gw <= '{1'b1, 8'h12 + 8'(34 * i), 8'hA0 + 8'(i)};
    end
    @(negedge i_clk);
    gw.en <= 1'b0;
    run(4'hA, cw(5'h1B, 3'h1, 8'h01, 2'h0), 32'h12345678);
    px(24'hA0A0A0, 24'hA1A1A1, 24'hA2A2A2, 24'h787878);
  endtask : t_gamma
  initial begin
    repeat (20) @(negedge i_clk);
    chk({23'h0, tout.valid}, 24'h0);
    i_resetn <= 1'b1;
    repeat (3) @(negedge i_clk);
    t_flags;
    t_rgba;
    t_bgr16;
    t_float;
    t_depth;
    t_index;
    t_yuv;
    t_gamma;
    end_sim;
  end
endmodule : texture_texel_format_decoder_bench
`default_nettype wire
